/* File: hdl/mifeb_consts.vh */
`ifndef MIFEB_CONSTS_VH
`define MIFEB_CONSTS_VH

// Register indices on the local port
`define MIFEB_ADDR_EDGE     4'h0
`define MIFEB_ADDR_CTRL0    4'h1
`define MIFEB_ADDR_CTRL1    4'h2
`define MIFEB_ADDR_CTRL2    4'h3
`define MIFEB_ADDR_HALL     4'h4
`define MIFEB_ADDR_CAPADC   4'h5
`define MIFEB_ADDR_PWM      4'h6
`define MIFEB_ADDR_TM01     4'h7
`define MIFEB_ADDR_TM2      4'h8
`define MIFEB_NUM_REGS      9

// Reset value of every register
`define MIFEB_RST_VAL       8'h00

// Implemented bits per register
`define MIFEB_MASK_EDGE     8'h7f
`define MIFEB_MASK_CTRL0    8'h7f
`define MIFEB_MASK_FULL     8'hff
`define MIFEB_MASK_HALL     8'h77
`define MIFEB_MASK_TM2      8'h33

// Field positions
`define MIFEB_HALL_SRC_BIT  6
`define MIFEB_HALL_C_LSB    4
`define MIFEB_HALL_B_LSB    2
`define MIFEB_HALL_A_LSB    0
`define MIFEB_GIE_BIT       0
`define MIFEB_FLAG_LSB      4
`define MIFEB_EN_LSB        0

// Edge field coding
`define MIFEB_EDGE_OFF      2'b00
`define MIFEB_EDGE_RISE     2'b01
`define MIFEB_EDGE_FALL     2'b10
`define MIFEB_EDGE_BOTH     2'b11

// Primary vector codes, lowest code wins
`define MIFEB_VEC_HALL      4'h0
`define MIFEB_VEC_EXT1      4'h1
`define MIFEB_VEC_CMP0      4'h2
`define MIFEB_VEC_TB        4'h3
`define MIFEB_VEC_MF1       4'h4
`define MIFEB_VEC_LVD       4'h5
`define MIFEB_VEC_EEP       4'h6
`define MIFEB_VEC_MF2       4'h7
`define MIFEB_VEC_MF3       4'h8
`define MIFEB_VEC_MF4       4'h9
`define MIFEB_VEC_I2C       4'ha
`define MIFEB_NUM_VEC       11

`endif

/* File: hdl/mifeb_edge_det.v */
`timescale 1ns/100ps
`include "mifeb_consts.vh"

module mifeb_edge_det
(
	input  wire       clk,
	input  wire       sys_rst,
	input  wire       raw_in,
	input  wire [1:0] mode,
	output reg        evt_r
);

reg  sync1_r;
reg  sync2_r;
reg  prev_r;
wire rise;
wire fall;
reg  hit_nxt;

assign rise = sync2_r & ~prev_r;
assign fall = ~sync2_r & prev_r;

always @*
begin
	case (mode)
		`MIFEB_EDGE_RISE: hit_nxt = rise; // RULE_02
		`MIFEB_EDGE_FALL: hit_nxt = fall; // RULE_02
		`MIFEB_EDGE_BOTH: hit_nxt = rise | fall; // RULE_02
		default:          hit_nxt = 1'b0;
	endcase
end

// Two flops before the edge detector; the first is read only by the second
always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		sync1_r <= 1'b0;
		sync2_r <= 1'b0;
		prev_r  <= 1'b0;
		evt_r   <= 1'b0;
	end
	else
	begin
		sync1_r <= raw_in; // RULE_26
		sync2_r <= sync1_r; // RULE_26
		prev_r  <= sync2_r;
		evt_r   <= hit_nxt; // RULE_26
	end
end

endmodule

/* File: hdl/mifeb_prio_enc.v */
`timescale 1ns/100ps
`include "mifeb_consts.vh"

module mifeb_prio_enc
(
	input  wire [10:0] pend,
	output reg         any,
	output reg  [3:0]  idx
);

integer k;

// Scan downward so the lowest index is left standing
always @*
begin
	any = 1'b0;
	idx = 4'h0;
	for (k = `MIFEB_NUM_VEC - 1; k >= 0; k = k - 1)
	begin
		if (pend[k])
		begin
			any = 1'b1;
			idx = k[3:0];
		end
	end
end

endmodule

/* File: hdl/mifeb_bank.v */
`timescale 1ns/100ps
`include "mifeb_consts.vh"

// What this block does
// RULE_01 - Source-select bit 6 picks Hall pins (0) or comparators 1-3 (1).
// RULE_02 - Bits 5:4 set Hall C edge: off, rising, falling, both.
// RULE_03 - Bits 3:2 set Hall B edge with the same coding.
// RULE_04 - Bits 1:0 set Hall A edge with the same coding.
// RULE_05 - Bit 0 of control 0 is the global enable; 0 blocks every request, flags still set.
// RULE_06 - Control 0 holds Hall summary flag at bit 4, enable bit 1.
// RULE_07 - Control 0 holds comparator 0 flag at bit 6, enable bit 3.
// RULE_08 - Control 0 holds external pin 1 flag at bit 5, enable bit 2.
// RULE_09 - Control 1 holds EEPROM write flag at bit 7, enable bit 3.
// RULE_10 - Control 1 holds low-voltage flag at bit 6, enable bit 2.
// RULE_11 - Control 1 holds group 1 flag at bit 5, enable bit 1.
// RULE_12 - Control 1 holds time base flag at bit 4, enable bit 0.
// RULE_13 - Control 2 holds I2C flag at bit 7, enable bit 3.
// RULE_14 - Control 2 holds group 2-4 flags at bits 4-6, enables 0-2.
// RULE_15 - Hall register holds A/B/C flags at bits 4-6, enables 0-2.
// RULE_16 - Capture compare flag bit 7/enable 3, overflow bit 6/enable 2.
// RULE_17 - ADC limit flag bit 5/enable 1, ADC done bit 4/enable 0.
// RULE_18 - PWM period flag at bit 7, enable at bit 3.
// RULE_19 - PWM duty 0-2 flags at bits 4-6, enables at bits 0-2.
// RULE_20 - Timer 0/1 P,A match flags at bits 4-7, enables at 0-3.
// RULE_21 - Unimplemented bits always read as zero.
// RULE_22 - Interrupt only when flag, its enable and global enable are set.
// RULE_23 - Taking an interrupt clears the global enable; flags keep setting.
// RULE_24 - Service clears the Hall summary flag; channel flags need software.
// RULE_25 - A group summary flag sets while any enabled member flag is set.
// RULE_26 - Hall and comparator inputs synchronised; flag sets cycle after edge; here the flag sets on the fourth clock after the input changes.
module mifeb_bank
(
	input  wire       clk,
	input  wire       sys_rst,
	input  wire [3:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata_r,
	input  wire [2:0] hall_input_pins,
	input  wire [2:0] hall_comparators,
	input  wire       comparator0_out,
	input  wire       ext_pin1_evt,
	input  wire       eeprom_write_evt,
	input  wire       low_voltage_evt,
	input  wire       timebase_evt,
	input  wire       i2c_evt,
	input  wire       capture_compare_evt,
	input  wire       capture_overflow_evt,
	input  wire       adc_limit_evt,
	input  wire       adc_done_evt,
	input  wire       pwm_period_evt,
	input  wire [2:0] pwm_duty_evt,
	input  wire       timer0_p_evt,
	input  wire       timer0_a_evt,
	input  wire       timer1_p_evt,
	input  wire       timer1_a_evt,
	input  wire       timer2_p_evt,
	input  wire       timer2_a_evt,
	input  wire       irq_ack,
	output reg        irq_req_r,
	output reg  [3:0] irq_vec_r
);

////////////////////////////////////////////////////////////////////////////////
// Register bank storage, flat: register n sits in bits 8n+7 .. 8n

wire [71:0] bank_q;
wire [71:0] set_all;
wire [71:0] clr_all;
wire [71:0] mask_all;

wire [7:0] edge_q;
wire [7:0] ctrl0_q;
wire [7:0] ctrl1_q;
wire [7:0] ctrl2_q;
wire [7:0] hall_q;
wire [7:0] capadc_q;
wire [7:0] pwm_q;
wire [7:0] tm01_q;
wire [7:0] tm2_q;

assign edge_q   = bank_q[7:0];
assign ctrl0_q  = bank_q[15:8];
assign ctrl1_q  = bank_q[23:16];
assign ctrl2_q  = bank_q[31:24];
assign hall_q   = bank_q[39:32];
assign capadc_q = bank_q[47:40];
assign pwm_q    = bank_q[55:48];
assign tm01_q   = bank_q[63:56];
assign tm2_q    = bank_q[71:64];

////////////////////////////////////////////////////////////////////////////////
// Hall channel source and edge detection

wire       hall_src;
wire [2:0] hall_raw;
wire [5:0] hall_modes;
wire [2:0] hall_evt;
wire       cmp0_evt;

assign hall_src   = edge_q[`MIFEB_HALL_SRC_BIT];
// Switching the source can itself look like an edge on a channel
assign hall_raw   = hall_src ? hall_comparators : hall_input_pins; // RULE_01
assign hall_modes = {edge_q[`MIFEB_HALL_C_LSB+1:`MIFEB_HALL_C_LSB], // RULE_02
                     edge_q[`MIFEB_HALL_B_LSB+1:`MIFEB_HALL_B_LSB], // RULE_03
                     edge_q[`MIFEB_HALL_A_LSB+1:`MIFEB_HALL_A_LSB]}; // RULE_04

genvar hi;
generate
	for (hi = 0; hi < 3; hi = hi + 1)
	begin : g_hall
		mifeb_edge_det u_edge
		(
			.clk     (clk),
			.sys_rst (sys_rst),
			.raw_in  (hall_raw[hi]),
			.mode    (hall_modes[2*hi+1:2*hi]),
			.evt_r   (hall_evt[hi])
		);
	end
endgenerate

// Comparator 0 requests on every change of its output
mifeb_edge_det u_cmp0
(
	.clk     (clk),
	.sys_rst (sys_rst),
	.raw_in  (comparator0_out),
	.mode    (`MIFEB_EDGE_BOTH),
	.evt_r   (cmp0_evt)
);

////////////////////////////////////////////////////////////////////////////////
// Group summaries: held up while any enabled member stays pending

wire hall_any;
wire mf1_any;
wire mf2_any;
wire mf3_any;
wire mf4_any;

assign hall_any = |(hall_q[6:4] & hall_q[2:0]); // RULE_25
assign mf1_any  = |(capadc_q[7:4] & capadc_q[3:0]); // RULE_25
assign mf2_any  = |(pwm_q[7:4] & pwm_q[3:0]); // RULE_25
assign mf3_any  = |(tm01_q[7:4] & tm01_q[3:0]); // RULE_25
assign mf4_any  = |(tm2_q[5:4] & tm2_q[1:0]); // RULE_25

////////////////////////////////////////////////////////////////////////////////
// Primary pending vector, indexed by vector code

wire        gie;
wire [10:0] pflag;
wire [10:0] pen;
wire [10:0] pend;
wire        pend_any;
wire [3:0]  pend_idx;

assign gie = ctrl0_q[`MIFEB_GIE_BIT]; // RULE_05

assign pflag = {ctrl2_q[7], // RULE_13
                ctrl2_q[6], // RULE_14
                ctrl2_q[5],
                ctrl2_q[4],
                ctrl1_q[7], // RULE_09
                ctrl1_q[6], // RULE_10
                ctrl1_q[5], // RULE_11
                ctrl1_q[4], // RULE_12
                ctrl0_q[6], // RULE_07
                ctrl0_q[5], // RULE_08
                ctrl0_q[4]}; // RULE_06

assign pen = {ctrl2_q[3],
              ctrl2_q[2],
              ctrl2_q[1],
              ctrl2_q[0],
              ctrl1_q[3],
              ctrl1_q[2],
              ctrl1_q[1],
              ctrl1_q[0],
              ctrl0_q[3],
              ctrl0_q[2],
              ctrl0_q[1]};

assign pend = pflag & pen; // RULE_22

mifeb_prio_enc u_prio
(
	.pend (pend),
	.any  (pend_any),
	.idx  (pend_idx)
);

////////////////////////////////////////////////////////////////////////////////
// Service: the acknowledged vector loses its flag, global enable drops

reg [10:0] svc_clr;
integer    vi;

always @*
begin
	svc_clr = 11'h000;
	for (vi = 0; vi < `MIFEB_NUM_VEC; vi = vi + 1)
	begin
		if (irq_ack && (irq_vec_r == vi[3:0]))
		begin
			svc_clr[vi] = 1'b1; // RULE_24
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Hardware set and clear terms per register

assign set_all[7:0]   = 8'h00;
assign set_all[15:8]  = {1'b0, cmp0_evt, ext_pin1_evt, hall_any, 4'h0};
assign set_all[23:16] = {eeprom_write_evt, low_voltage_evt, mf1_any, timebase_evt,
                         4'h0};
assign set_all[31:24] = {i2c_evt, mf4_any, mf3_any, mf2_any, 4'h0};
assign set_all[39:32] = {1'b0, hall_evt[2], hall_evt[1], hall_evt[0], 4'h0}; // RULE_15
assign set_all[47:40] = {capture_compare_evt, capture_overflow_evt, // RULE_16
                         adc_limit_evt, adc_done_evt, 4'h0}; // RULE_17
assign set_all[55:48] = {pwm_period_evt, pwm_duty_evt[2], // RULE_18
                         pwm_duty_evt[1], pwm_duty_evt[0], 4'h0}; // RULE_19
assign set_all[63:56] = {timer1_a_evt, timer1_p_evt, // RULE_20
                         timer0_a_evt, timer0_p_evt, 4'h0};
assign set_all[71:64] = {2'b00, timer2_a_evt, timer2_p_evt, 4'h0};

assign clr_all[7:0]   = 8'h00;
assign clr_all[15:8]  = {1'b0, svc_clr[2], svc_clr[1], svc_clr[0], 3'b000,
                         irq_ack}; // RULE_23
assign clr_all[23:16] = {svc_clr[6], svc_clr[5], svc_clr[4], svc_clr[3], 4'h0};
assign clr_all[31:24] = {svc_clr[10], svc_clr[9], svc_clr[8], svc_clr[7], 4'h0};
assign clr_all[71:32] = 40'h00_0000_0000;

assign mask_all[7:0]   = `MIFEB_MASK_EDGE;
assign mask_all[15:8]  = `MIFEB_MASK_CTRL0;
assign mask_all[23:16] = `MIFEB_MASK_FULL;
assign mask_all[31:24] = `MIFEB_MASK_FULL;
assign mask_all[39:32] = `MIFEB_MASK_HALL;
assign mask_all[47:40] = `MIFEB_MASK_FULL;
assign mask_all[55:48] = `MIFEB_MASK_FULL;
assign mask_all[63:56] = `MIFEB_MASK_FULL;
assign mask_all[71:64] = `MIFEB_MASK_TM2;

////////////////////////////////////////////////////////////////////////////////
// One storage process per register; a hardware set beats any clear

genvar ri;
generate
	for (ri = 0; ri < `MIFEB_NUM_REGS; ri = ri + 1)
	begin : g_reg
		localparam integer IDX = ri;
		reg  [7:0] q_r;
		wire [7:0] q_nxt;
		wire       hit;

		assign hit   = reg_wr && ({28'h000_0000, reg_addr} == IDX);
		// Only flag bits have set terms, so enables store the write as is
		assign q_nxt = (set_all[8*ri+7:8*ri] |
		                (hit ? reg_wdata : (q_r & ~clr_all[8*ri+7:8*ri])))
		               & mask_all[8*ri+7:8*ri]; // RULE_21

		always @(posedge clk or posedge sys_rst)
		begin
			if (sys_rst)
			begin
				q_r <= `MIFEB_RST_VAL;
			end
			else
			begin
				q_r <= q_nxt; // RULE_23
			end
		end

		assign bank_q[8*ri+7:8*ri] = q_r;
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Request to the core

reg       irq_req_nxt;
reg [3:0] irq_vec_nxt;

always @*
begin
	// The ack cycle drops the request at once, not after the enable clears
	irq_req_nxt = gie & pend_any & ~irq_ack; // RULE_22
	irq_vec_nxt = irq_vec_r;
	if (pend_any && !irq_ack)
	begin
		irq_vec_nxt = pend_idx;
	end
end

always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		irq_req_r <= 1'b0;
		irq_vec_r <= `MIFEB_VEC_HALL;
	end
	else
	begin
		irq_req_r <= irq_req_nxt; // RULE_05
		irq_vec_r <= irq_vec_nxt;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read port: data in the cycle after the strobe only

reg [7:0] rd_nxt;

always @*
begin
	rd_nxt = 8'h00;
	if (reg_rd)
	begin
		case (reg_addr)
			`MIFEB_ADDR_EDGE:   rd_nxt = edge_q;
			`MIFEB_ADDR_CTRL0:  rd_nxt = ctrl0_q;
			`MIFEB_ADDR_CTRL1:  rd_nxt = ctrl1_q;
			`MIFEB_ADDR_CTRL2:  rd_nxt = ctrl2_q;
			`MIFEB_ADDR_HALL:   rd_nxt = hall_q;
			`MIFEB_ADDR_CAPADC: rd_nxt = capadc_q;
			`MIFEB_ADDR_PWM:    rd_nxt = pwm_q;
			`MIFEB_ADDR_TM01:   rd_nxt = tm01_q;
			`MIFEB_ADDR_TM2:    rd_nxt = tm2_q;
			default:            rd_nxt = 8'h00; // RULE_21
		endcase
	end
end

always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		reg_rdata_r <= 8'h00;
	end
	else
	begin
		reg_rdata_r <= rd_nxt;
	end
end

endmodule

/* File: sim/mifeb_core_model.sv */
`timescale 1ns/100ps
module mifeb_core_model
(
	input  wire       clk,
	input  wire       sys_rst,
	input  wire       irq_req_r,
	input  wire [3:0] ack_dly,
	output reg        irq_ack_r
);
reg [3:0] wait_r;
// A slow core lets the request stand ack_dly cycles before taking it
always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		irq_ack_r <= 1'b0;
		wait_r    <= 4'h0;
	end
	else if (irq_req_r && !irq_ack_r && wait_r == ack_dly)
	begin
		irq_ack_r <= 1'b1;
		wait_r    <= 4'h0;
	end
	else
	begin
		irq_ack_r <= 1'b0;
		wait_r    <= (irq_req_r && !irq_ack_r) ? wait_r + 4'h1 : 4'h0;
	end
end
endmodule

/* File: sim/mifeb_bank_assertions.sv */
`timescale 1ns/100ps
module mifeb_bank_assertions
(
	input wire       clk,
	input wire       sys_rst,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata_r,
	input wire       timer0_p_evt,
	input wire [2:0] pwm_duty_evt,
	input wire       irq_ack,
	input wire       irq_req_r,
	input wire [3:0] irq_vec_r
);
default clocking cb @(posedge clk);
endclocking
default disable iff (sys_rst);
function automatic [7:0] rsvd_mask(input [3:0] a);
	case (a)
		4'h0, 4'h1: rsvd_mask = 8'h80;
		4'h4: rsvd_mask = 8'h88;
		4'h8: rsvd_mask = 8'hcc;
		4'h2, 4'h3, 4'h5, 4'h6, 4'h7: rsvd_mask = 8'h00;
		default: rsvd_mask = 8'hff;
	endcase
endfunction
sequence s_no_gie_wr;
	!(reg_wr && reg_addr == 4'h1);
endsequence
sequence s_gie_off;
	reg_wr && reg_addr == 4'h1 && !reg_wdata[0];
endsequence
sequence s_ack_kept;
	irq_ack && !(reg_wr && reg_addr == 4'h1);
endsequence
////////////////////////////////////////////////////////////////
a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_r == 8'h00)
	else $error("Read data not zero outside read slot");
a_rsvd_zero: assert property ($past(reg_rd) |-> (reg_rdata_r & rsvd_mask($past(reg_addr))) == 8'h00)
	else $error("Unimplemented bit read as one");
a_edge_rw: assert property (reg_wr && reg_addr == 4'h0 ##1 !reg_wr ##1 reg_rd && reg_addr == 4'h0
	|=> reg_rdata_r == ($past(reg_wdata, 3) & 8'h7f))
	else $error("Edge select readback wrong");
a_ack_drop: assert property (irq_ack |=> !irq_req_r)
	else $error("Request stands after ack");
a_ack_gie: assert property (s_ack_kept ##1 s_no_gie_wr |=> !irq_req_r)
	else $error("Request back without global enable");
a_gie_off: assert property (s_gie_off ##1 s_no_gie_wr |=> !irq_req_r)
	else $error("Request while global enable off");
a_tm0_flag: assert property (timer0_p_evt ##1 !reg_wr ##1 reg_rd && reg_addr == 4'h7 |=> reg_rdata_r[4])
	else $error("Timer 0 P flag not set");
a_duty_flag: assert property (pwm_duty_evt[2] ##1 !reg_wr ##1 reg_rd && reg_addr == 4'h6 |=> reg_rdata_r[6])
	else $error("PWM duty 2 flag not set");
a_vec_range: assert property (irq_req_r |-> irq_vec_r < 4'hb)
	else $error("Vector code out of range");
endmodule
bind mifeb_bank mifeb_bank_assertions mifeb_bank_assertions_inst
(
	.clk(clk),
	.sys_rst(sys_rst),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata_r(reg_rdata_r),
	.timer0_p_evt(timer0_p_evt),
	.pwm_duty_evt(pwm_duty_evt),
	.irq_ack(irq_ack),
	.irq_req_r(irq_req_r),
	.irq_vec_r(irq_vec_r)
);

/* File: sim/test_mifeb_bank.sv */
`timescale 1ns/100ps
module test_mifeb_bank;
logic        clk = 1'b0;
logic        sys_rst = 1'b1;
logic [3:0]  reg_addr = 4'h0;
logic [7:0]  reg_wdata = 8'h00;
logic        reg_wr = 1'b0;
logic        reg_rd = 1'b0;
logic [7:0]  reg_rdata_r;
logic [2:0]  pins = 3'h0;
logic [2:0]  cmps = 3'h0;
logic        cmp0 = 1'b0;
logic [18:0] ev = 19'h0_0000;
logic [3:0]  ack_dly = 4'h0;
logic        irq_ack;
logic        irq_req_r;
logic [3:0]  irq_vec_r;
int          n_fail = 0;
int          n_compared = 0;
// Event index to register index (high nibble) and flag bit (low bits)
localparam logic [7:0] ev_map [0:18] = '{8'h15, 8'h27, 8'h26, 8'h24, 8'h37, 8'h57, 8'h56,
	8'h55, 8'h54, 8'h67, 8'h64, 8'h65, 8'h66, 8'h74, 8'h75, 8'h76, 8'h77, 8'h84, 8'h85};
localparam logic [7:0] rw_mask [0:8] = '{8'h7f, 8'h7e, 8'hff, 8'hff, 8'h77, 8'hff,
	8'hff, 8'hff, 8'h33};
mifeb_bank mifeb_bank_inst
(
	.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
	.hall_input_pins(pins), .hall_comparators(cmps), .comparator0_out(cmp0),
	.ext_pin1_evt(ev[0]), .eeprom_write_evt(ev[1]), .low_voltage_evt(ev[2]),
	.timebase_evt(ev[3]), .i2c_evt(ev[4]), .capture_compare_evt(ev[5]),
	.capture_overflow_evt(ev[6]), .adc_limit_evt(ev[7]), .adc_done_evt(ev[8]),
	.pwm_period_evt(ev[9]), .pwm_duty_evt(ev[12:10]), .timer0_p_evt(ev[13]),
	.timer0_a_evt(ev[14]), .timer1_p_evt(ev[15]), .timer1_a_evt(ev[16]),
	.timer2_p_evt(ev[17]), .timer2_a_evt(ev[18]), .irq_ack(irq_ack),
	.irq_req_r(irq_req_r), .irq_vec_r(irq_vec_r)
);
mifeb_core_model mifeb_core_model_inst
(
	.clk(clk), .sys_rst(sys_rst), .irq_req_r(irq_req_r), .ack_dly(ack_dly),
	.irq_ack_r(irq_ack)
);
initial forever #12.5 clk = ~clk;
////////////////////////////////////////////////////////////////
task automatic chk(input logic [7:0] g, input logic [7:0] e);
	n_compared++;
	if (g !== e)
	begin
		n_fail++;
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
	end
endtask
task automatic close_out();
	$display("Compared %0d, failed %0d", n_compared, n_fail);
	if (n_fail == 0 && n_compared > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask
task automatic wr(input logic [3:0] a, input logic [7:0] d);
	@(posedge clk);
	reg_wr    <= 1'b1;
	reg_addr  <= a;
	reg_wdata <= d;
	@(posedge clk);
	reg_wr <= 1'b0;
endtask
task automatic rd(input logic [3:0] a, input logic [7:0] e);
	@(posedge clk);
	reg_rd   <= 1'b1;
	reg_addr <= a;
	@(posedge clk);
	reg_rd <= 1'b0;
	#1;
	chk(reg_rdata_r, e);
endtask
task automatic pulse(input logic [18:0] v);
	@(posedge clk);
	ev <= v;
	@(posedge clk);
	ev <= 19'h0_0000;
endtask
// Bounded wait, so a request that never comes ends the run
task automatic wait_req(input logic [3:0] v);
	int k;
	#1;
	for (k = 0; k < 20 && irq_req_r !== 1'b1; k++)
	begin
		@(posedge clk);
		#1;
	end
	if (k == 20)
	begin
		n_fail++;
		close_out();
	end
	else
		chk({4'h0, irq_vec_r}, {4'h0, v});
endtask
////////////////////////////////////////////////////////////////
task automatic t_reset();
	#1;
	chk({7'h00, irq_req_r}, 8'h00);
	for (int a = 0; a < 9; a++)
		rd(a[3:0], 8'h00);
endtask
task automatic t_regs();
	// Write then read back at once, so the edge readback assertion fires
	wr(4'h0, 8'hd5);
	rd(4'h0, 8'h55);
	// Global enable stays off so written flags raise no request
	for (int a = 0; a < 9; a++)
		wr(a[3:0], a == 1 ? 8'h7e : 8'hff);
	wr(4'h9, 8'hff);
	for (int a = 0; a < 9; a++)
		rd(a[3:0], rw_mask[a]);
	rd(4'h9, 8'h00);
	rd(4'hf, 8'h00);
	for (int a = 8; a >= 0; a--)
		wr(a[3:0], 8'h00);
endtask
task automatic t_edges();
	for (int c = 0; c < 3; c++)
		for (int m = 0; m < 4; m++)
		begin
			wr(4'h0, 8'(m << (2 * c)));
			pins <= 3'(1 << c);
			repeat (6) @(posedge clk);
			rd(4'h4, 8'((m & 1) << (4 + c)));
			wr(4'h4, 8'h00);
			pins <= 3'h0;
			repeat (6) @(posedge clk);
			rd(4'h4, 8'(((m >> 1) & 1) << (4 + c)));
			wr(4'h4, 8'h00);
		end
endtask
task automatic t_src();
	wr(4'h0, 8'h41);
	pins <= 3'h1;
	repeat (6) @(posedge clk);
	rd(4'h4, 8'h00);
	@(posedge clk);
	cmps <= 3'h1;
	repeat (6) @(posedge clk);
	rd(4'h4, 8'h10);
	wr(4'h0, 8'h00);
	wr(4'h4, 8'h00);
	pins <= 3'h0;
	cmps <= 3'h0;
endtask
task automatic t_events();
	for (int i = 0; i < 19; i++)
	begin
		pulse(19'(1 << i));
		rd(ev_map[i][7:4], 8'(1 << ev_map[i][2:0]));
		wr(ev_map[i][7:4], 8'h00);
	end
	cmp0 <= 1'b1;
	repeat (6) @(posedge clk);
	rd(4'h1, 8'h40);
	wr(4'h1, 8'h00);
endtask
task automatic t_irq_grp();
	ack_dly <= 4'h3;
	wr(4'h7, 8'h01);
	wr(4'h3, 8'h02);
	pulse(19'h0_2000);
	rd(4'h3, 8'h22);
	chk({7'h00, irq_req_r}, 8'h00);
	wr(4'h1, 8'h01);
	wait_req(4'h8);
	repeat (6) @(posedge clk);
	rd(4'h1, 8'h00);
	rd(4'h3, 8'h22);
	pulse(19'h0_8000);
	rd(4'h7, 8'h51);
	wr(4'h7, 8'h00);
	wr(4'h3, 8'h00);
endtask
task automatic t_irq_en();
	ack_dly <= 4'h0;
	wr(4'h1, 8'h01);
	pulse(19'h0_0001);
	repeat (4) @(posedge clk);
	#1;
	chk({7'h00, irq_req_r}, 8'h00);
	rd(4'h1, 8'h21);
	wr(4'h1, 8'h25);
	wait_req(4'h1);
	repeat (4) @(posedge clk);
	rd(4'h1, 8'h04);
	wr(4'h1, 8'h00);
endtask
task automatic t_irq_hall();
	// Hall A rising edge through the summary flag to vector 0
	wr(4'h0, 8'h01);
	wr(4'h4, 8'h01);
	wr(4'h1, 8'h03);
	pins <= 3'h1;
	wait_req(4'h0);
	repeat (4) @(posedge clk);
	rd(4'h4, 8'h11);
	rd(4'h1, 8'h12);
	wr(4'h4, 8'h00);
	wr(4'h1, 8'h00);
	rd(4'h1, 8'h00);
	wr(4'h0, 8'h00);
	pins <= 3'h0;
	// Summary set by software alone: service must clear it
	wr(4'h1, 8'h13);
	wait_req(4'h0);
	repeat (4) @(posedge clk);
	rd(4'h1, 8'h02);
	wr(4'h1, 8'h00);
endtask
////////////////////////////////////////////////////////////////
initial
begin
	repeat (2) @(posedge clk);
	sys_rst <= 1'b0;
	t_reset();
	t_regs();
	t_edges();
	t_src();
	t_events();
	t_irq_grp();
	t_irq_en();
	t_irq_hall();
	close_out();
end
endmodule
